//--- inc/ptt_pkg.sv
// constants, types and helper functions of the table transfer block
// assumes one core clock; the core stalls while busy is high
// Summary of operation
// R1: a table read first copies the latch high byte (t=1) or low byte (t=0) to file f.
// R2: the table read then refills the whole 16-bit latch from program memory at the pointer.
// R3: a table read ends by adding one to the pointer when i is 1.
// R4: a table read is a three-step sequence, one step longer when f is the program counter.
// R5: a table write first loads file f data into the latch low byte (t=0) or high byte (t=1).
// R6: the table write then stores the whole latch at the pointer and increments it when i is 1.
// R7: a pointer in external memory gives an external bus write and a two-step write.
// R8: a pointer in on-chip memory starts a programming sequence that an interrupt ends.
// R9: with global interrupt disable set, the ending interrupt only completes the write.
// R10: with global interrupt disable clear, service is requested right after the write.
// R11: software should mask auto-cleared sources before table writes to keep pending flags.
// R12: only an enabled source ends programming; pin, timer overflow and capture flags clear.
`default_nettype none
package ptt_pkg;

	localparam logic [5:0] OP_READ_PREFIX  = 6'h2a;
	localparam logic [5:0] OP_WRITE_PREFIX = 6'h2b;
	localparam int         OP_T_BIT        = 9;
	localparam int         OP_I_BIT        = 8;
	localparam logic [7:0] FILE_PROGRAM_COUNTER = 8'h02;

	// interrupt source positions
	localparam int IRQ_W            = 4;
	localparam int IRQ_EXT_PIN      = 0;
	localparam int IRQ_TIMER_OVF    = 1;
	localparam int IRQ_TIMER3_CAP   = 2;
	localparam logic [IRQ_W-1:0] IRQ_AUTO_CLEAR = 4'h7;

	// register port offsets and status bit positions
	localparam logic [2:0] REG_PTR_LO   = 3'h0;
	localparam logic [2:0] REG_PTR_HI   = 3'h1;
	localparam logic [2:0] REG_LATCH_LO = 3'h2;
	localparam logic [2:0] REG_LATCH_HI = 3'h3;
	localparam logic [2:0] REG_STATUS   = 3'h4;
	localparam int         STAT_BUSY    = 0;
	localparam int         STAT_PROG    = 1;

	localparam logic [15:0] RST_PTR   = 16'h0000;
	localparam logic [15:0] RST_LATCH = 16'h0000;

	typedef enum logic [2:0] {
		PTT_IDLE,
		PTT_RD_WAIT,
		PTT_RD_LOAD,
		PTT_RD_PC,
		PTT_WR_ISSUE,
		PTT_WR_PROG
	} ptt_state_t;

	typedef struct packed {
		logic       is_read;
		logic       is_write;
		logic       t;
		logic       i;
		logic [7:0] f;
	} ptt_dec_t;

	typedef struct packed {
		ptt_state_t       st;
		logic [15:0]      latch;
		logic [15:0]      ptr;
		ptt_dec_t         op;
		logic             fw_en;
		logic [7:0]       fw_addr;
		logic [7:0]       fw_data;
		logic             pm_rd_en;
		logic [15:0]      pm_addr;
		logic             ext_wr_en;
		logic [15:0]      ext_addr;
		logic [15:0]      ext_data;
		logic             prog_active;
		logic [15:0]      prog_addr;
		logic [IRQ_W-1:0] flag_clr;
		logic             service_req;
		logic             done;
		logic             busy;
		logic [7:0]       rdata;
	} ptt_regs_t;

	function automatic logic ptt_is_external(input logic [15:0] a, input logic [15:0] last);
		return a > last;
	endfunction

	function automatic logic [15:0] ptt_bump(input logic [15:0] p, input logic inc);
		return inc ? p + 16'h0001 : p;
	endfunction

endpackage
`default_nettype wire

//--- src/ptt_decode.sv
// opcode decoder of the table transfer block
// assumes the opcode is stable while instr_valid is high
`default_nettype none
module ptt_decode (
	// instruction word
	input  wire logic [15:0]       opcode,
	// decoded fields
	output var  ptt_pkg::ptt_dec_t dec
);
	import ptt_pkg::*;

	always_comb begin
		dec.is_read  = opcode[15:10] == OP_READ_PREFIX;
		dec.is_write = opcode[15:10] == OP_WRITE_PREFIX;
		dec.t        = opcode[OP_T_BIT];
		dec.i        = opcode[OP_I_BIT];
		dec.f        = opcode[7:0];
	end

endmodule
`default_nettype wire

//--- src/ptt_table_xfer.sv
// table read / table write sequencer with pointer and latch
// assumes core logic on the same clock; program memory answers one cycle after a read
//
// Implementation choices: the register offsets and strobed register access.
`default_nettype none
module ptt_table_xfer (
	// clock and reset
	input  wire logic                    clk,
	input  wire logic                    reset_n,
	// instruction from the core
	input  wire logic                    instr_valid,
	input  wire logic [15:0]             opcode,
	input  wire logic [7:0]              file_rdata,
	// file register write back
	output logic                         file_wr_en,
	output logic [7:0]                   file_wr_addr,
	output logic [7:0]                   file_wr_data,
	// program memory read
	output logic                         pm_rd_en,
	output logic [15:0]                  pm_rd_addr,
	input  wire logic [15:0]             pm_rdata,
	// external program memory write
	output logic                         ext_wr_en,
	output logic [15:0]                  ext_wr_addr,
	output logic [15:0]                  ext_wr_data,
	// on-chip array programming
	input  wire logic [15:0]             onchip_last,
	output logic                         prog_active,
	output logic [15:0]                  prog_addr,
	output logic [15:0]                  prog_data,
	// interrupt controller side
	input  wire logic [ptt_pkg::IRQ_W-1:0] irq_flag,
	input  wire logic [ptt_pkg::IRQ_W-1:0] irq_enable,
	input  wire logic                    global_interrupt_disable,
	output logic [ptt_pkg::IRQ_W-1:0]    irq_flag_clr,
	output logic                         service_req,
	// sequence status
	output logic                         busy,
	output logic                         done,
	// register port
	input  wire logic [2:0]              reg_addr,
	input  wire logic [7:0]              reg_wdata,
	input  wire logic                    reg_wr,
	input  wire logic                    reg_rd,
	output logic [7:0]                   reg_rdata
);
	import ptt_pkg::*;

	ptt_regs_t        s_r;
	ptt_regs_t        s_nxt;
	ptt_dec_t         dec;
	logic [IRQ_W-1:0] term;
	logic [15:0]      ptr_sw;

	// replaces one byte of a word; pointer, latch and write-op loads share it
	function automatic logic [15:0] put_byte(
		input logic [15:0] w,
		input logic        hi,
		input logic [7:0]  b
	);
		logic [15:0] r;
		r = w;
		if (hi) begin
			r[15:8] = b;
		end else begin
			r[7:0] = b;
		end
		return r;
	endfunction

	function automatic logic [7:0] get_byte(
		input logic [15:0] w,
		input logic        hi
	);
		return hi ? w[15:8] : w[7:0];
	endfunction

	// every sequence ends alike: one done pulse in the same cycle it is idle again
	function automatic ptt_regs_t seq_close(
		input ptt_regs_t s
	);
		ptt_regs_t r;
		r      = s;
		r.done = 1'b1;
		r.st   = PTT_IDLE;
		return r;
	endfunction

	// common close of a table write, short or long
	function automatic ptt_regs_t write_close(
		input ptt_regs_t        s,
		input logic [15:0]      p,
		input logic [IRQ_W-1:0] t
	);
		ptt_regs_t r;
		r          = seq_close(s);
		r.ptr      = ptt_bump(p, s.op.i); // see R6
		// short writes clear the same flags as long ones
		r.flag_clr = t & IRQ_AUTO_CLEAR; // see R12
		return r;
	endfunction

	// register port view; unmapped offsets read as zero
	function automatic logic [7:0] reg_view(
		input logic [2:0] a,
		input ptt_regs_t  s
	);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			REG_PTR_LO: begin
				v = get_byte(s.ptr, 1'b0);
			end
			REG_PTR_HI: begin
				v = get_byte(s.ptr, 1'b1);
			end
			REG_LATCH_LO: begin
				v = get_byte(s.latch, 1'b0);
			end
			REG_LATCH_HI: begin
				v = get_byte(s.latch, 1'b1);
			end
			REG_STATUS: begin
				v[STAT_BUSY] = s.busy;
				v[STAT_PROG] = s.prog_active;
			end
			default: begin
				v = 8'h00;
			end
		endcase
		return v;
	endfunction

	ptt_decode u_dec (
		.opcode (opcode),
		.dec    (dec)
	);

	// only enabled sources may end programming
	assign term = irq_flag & irq_enable; // see R12

	// software pointer view, applied before the sequencer looks at it
	always_comb begin
		ptr_sw = s_r.ptr;
		// same-cycle software write wins; a following increment adds onto it
		if (reg_wr && reg_addr == REG_PTR_LO) begin
			ptr_sw = put_byte(ptr_sw, 1'b0, reg_wdata);
		end
		if (reg_wr && reg_addr == REG_PTR_HI) begin
			ptr_sw = put_byte(ptr_sw, 1'b1, reg_wdata);
		end
	end

	always_comb begin
		s_nxt             = s_r;
		s_nxt.fw_en       = 1'b0;
		s_nxt.pm_rd_en    = 1'b0;
		s_nxt.ext_wr_en   = 1'b0;
		s_nxt.flag_clr    = '0;
		s_nxt.service_req = 1'b0;
		s_nxt.done        = 1'b0;
		s_nxt.ptr         = ptr_sw;

		if (reg_wr && reg_addr == REG_LATCH_LO) begin
			s_nxt.latch = put_byte(s_nxt.latch, 1'b0, reg_wdata);
		end
		if (reg_wr && reg_addr == REG_LATCH_HI) begin
			s_nxt.latch = put_byte(s_nxt.latch, 1'b1, reg_wdata);
		end

		case (s_r.st)
			PTT_IDLE: begin
				if (instr_valid && dec.is_read) begin
					s_nxt.op       = dec;
					s_nxt.fw_en    = 1'b1;
					s_nxt.fw_addr  = dec.f;
					// byte leaves before the refill overwrites it
					s_nxt.fw_data  = get_byte(s_r.latch, dec.t); // see R1
					s_nxt.pm_rd_en = 1'b1;
					s_nxt.pm_addr  = ptr_sw;
					s_nxt.st       = PTT_RD_WAIT;
				end else if (instr_valid && dec.is_write) begin
					s_nxt.op = dec;
					s_nxt.latch = put_byte(s_nxt.latch, dec.t, file_rdata); // see R5
					s_nxt.st = PTT_WR_ISSUE;
				end
			end

			PTT_RD_WAIT: begin
				s_nxt.st = PTT_RD_LOAD;
			end

			PTT_RD_LOAD: begin
				s_nxt.latch = pm_rdata; // see R2
				s_nxt.ptr   = ptt_bump(ptr_sw, s_r.op.i); // see R3
				// a program counter destination costs one extra step
				if (s_r.op.f == FILE_PROGRAM_COUNTER) begin
					s_nxt.st = PTT_RD_PC; // see R4
				end else begin
					s_nxt = seq_close(s_nxt); // see R4
				end
			end

			PTT_RD_PC: begin
				s_nxt = seq_close(s_nxt); // see R4
			end

			PTT_WR_ISSUE: begin
				if (ptt_is_external(ptr_sw, onchip_last)) begin
					s_nxt.ext_wr_en = 1'b1; // see R7
					s_nxt.ext_addr  = ptr_sw; // see R6
					s_nxt.ext_data  = s_r.latch; // see R6
					// two-step write: closes in the same cycle that issues the bus write
					s_nxt           = write_close(s_nxt, ptr_sw, term); // see R7
				end else begin
					s_nxt.prog_active = 1'b1; // see R8
					s_nxt.prog_addr   = ptr_sw; // see R6
					s_nxt.st          = PTT_WR_PROG;
				end
			end

			PTT_WR_PROG: begin
				// no time limit: a masked-off system programs forever
				if (|term) begin
					s_nxt.prog_active = 1'b0; // see R8
					s_nxt.service_req = !global_interrupt_disable; // see R9 see R10
					s_nxt             = write_close(s_nxt, ptr_sw, term); // see R12
				end
			end

			default: begin
				s_nxt.st          = PTT_IDLE;
				s_nxt.prog_active = 1'b0;
			end
		endcase

		// read data stands only in the cycle after the strobe
		s_nxt.rdata = 8'h00;
		if (reg_rd) begin
			s_nxt.rdata = reg_view(reg_addr, s_r);
		end
		// busy leaves through a flop like every other port
		s_nxt.busy = s_nxt.st != PTT_IDLE;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_r             <= '0;
			s_r.st          <= PTT_IDLE;
			s_r.latch       <= RST_LATCH;
			s_r.ptr         <= RST_PTR;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign file_wr_en   = s_r.fw_en;
	assign file_wr_addr = s_r.fw_addr;
	assign file_wr_data = s_r.fw_data;
	assign pm_rd_en     = s_r.pm_rd_en;
	assign pm_rd_addr   = s_r.pm_addr;
	assign ext_wr_en    = s_r.ext_wr_en;
	assign ext_wr_addr  = s_r.ext_addr;
	assign ext_wr_data  = s_r.ext_data;
	assign prog_active  = s_r.prog_active;
	assign prog_addr    = s_r.prog_addr;
	assign prog_data    = s_r.latch;
	assign irq_flag_clr = s_r.flag_clr;
	assign service_req  = s_r.service_req;
	assign busy         = s_r.busy;
	assign done         = s_r.done;
	assign reg_rdata    = s_r.rdata;

endmodule
`default_nettype wire

//--- test/ptt_table_xfer_props.sv
// checker for the table transfer sequencer ports
// assumes one clock domain and its active-low reset
`default_nettype none
module ptt_table_xfer_props (
	// clock and reset
	input wire logic	clk,
	input wire logic	reset_n,
	// watched ports
	input wire logic	instr_valid,
	input wire logic [15:0]	opcode,
	input wire logic	busy,
	input wire logic	done,
	input wire logic	file_wr_en,
	input wire logic	pm_rd_en,
	input wire logic	ext_wr_en,
	input wire logic	prog_active,
	input wire logic	service_req,
	input wire logic	global_interrupt_disable,
	input wire logic [ptt_pkg::IRQ_W-1:0]	irq_flag,
	input wire logic [ptt_pkg::IRQ_W-1:0]	irq_enable,
	input wire logic [ptt_pkg::IRQ_W-1:0]	irq_flag_clr
);
	timeunit 1ns;
	timeprecision 1ps;
	import ptt_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	wire hit = |(irq_flag & irq_enable);
	sequence s_take(logic [5:0] p);
		instr_valid && !busy && opcode[15:10] == p;
	endsequence
	sequence s_rd(logic pc);
		s_take(OP_READ_PREFIX) ##0 ((opcode[7:0] == FILE_PROGRAM_COUNTER) == pc);
	endsequence
	chk_rd_step: assert property (s_take(OP_READ_PREFIX) |=> file_wr_en && pm_rd_en)
		else $error("read first step missing");
	chk_rd_len: assert property (s_rd(1'b0) |=> !done ##1 !done ##1 done)
		else $error("read length wrong");
	chk_rd_pc: assert property (s_rd(1'b1) |=> !done [*3] ##1 done)
		else $error("read to pc length wrong");
	chk_wr_step: assert property (s_take(OP_WRITE_PREFIX) |=> busy ##1 (ext_wr_en && done || prog_active))
		else $error("write second step wrong");
	chk_prog_hold: assert property (prog_active && !hit |=> prog_active && !done)
		else $error("programming ended early");
	chk_prog_end: assert property (prog_active && hit |=> !prog_active && done)
		else $error("programming not ended");
	chk_svc_on: assert property (prog_active && hit && !global_interrupt_disable |=> service_req)
		else $error("service not requested");
	chk_svc_off: assert property (service_req |-> done && !$past(global_interrupt_disable))
		else $error("service while disabled");
	chk_clr_src: assert property (|irq_flag_clr |-> done
		&& (irq_flag_clr & ~(IRQ_AUTO_CLEAR & $past(irq_enable) & $past(irq_flag))) == '0)
		else $error("wrong flag cleared");
endmodule
`default_nettype wire

//--- test/ptt_mem_model.sv
// program memory partner: array read port and external write port
// assumes 256 words; upper address bits alias
`default_nettype none
module ptt_mem_model (
	// clock
	input wire logic	clk,
	// program memory read
	input wire logic	pm_rd_en,
	input wire logic [15:0]	pm_rd_addr,
	output logic [15:0]	pm_rdata,
	// external write
	input wire logic	ext_wr_en,
	input wire logic [15:0]	ext_wr_addr,
	input wire logic [15:0]	ext_wr_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [256];
	initial begin
		pm_rdata = 16'h0000;
		for (int a = 0; a < 256; a++) mem[a] = {a[7:0], ~a[7:0]};
	end
	// stale data inverted each cycle so a sample an odd number of cycles late never matches
	always @(posedge clk) begin
		pm_rdata <= pm_rd_en ? mem[pm_rd_addr[7:0]] : ~pm_rdata;
		if (ext_wr_en) mem[ext_wr_addr[7:0]] <= ext_wr_data;
	end
endmodule
`default_nettype wire

//--- test/ptt_table_xfer_tb.sv
// self-checking bench of the table transfer sequencer
// assumes the memory model and the bound checker
`default_nettype none
module ptt_table_xfer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ptt_pkg::*;
	logic clk = 0, reset_n = 0, instr_valid = 0, reg_wr = 0, reg_rd = 0;
	logic global_interrupt_disable = 0, file_wr_en, pm_rd_en, ext_wr_en;
	logic prog_active, service_req, busy, done, sv;
	logic [15:0] opcode = '0, onchip_last = 16'h00ff, pm_rdata, pm_rd_addr;
	logic [15:0] ext_wr_addr, ext_wr_data, prog_addr, prog_data, fa, fd, pa, ea, ed, pg, pd;
	logic [7:0] file_rdata = 8'h00, reg_wdata = 8'h00, file_wr_addr, file_wr_data, reg_rdata;
	logic [2:0] reg_addr = 3'h0;
	logic [IRQ_W-1:0] irq_flag = '0, irq_enable = '0, irq_flag_clr, cl;
	int failures = 0, total_checks = 0, n;
	ptt_table_xfer ptt_table_xfer_inst (.clk, .reset_n, .instr_valid, .opcode, .file_rdata,
		.file_wr_en, .file_wr_addr, .file_wr_data, .pm_rd_en, .pm_rd_addr, .pm_rdata,
		.ext_wr_en, .ext_wr_addr, .ext_wr_data, .onchip_last, .prog_active, .prog_addr,
		.prog_data, .irq_flag, .irq_enable, .global_interrupt_disable, .irq_flag_clr,
		.service_req, .busy, .done, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
	ptt_mem_model ptt_mem_model_inst (.clk, .pm_rd_en, .pm_rd_addr, .pm_rdata,
		.ext_wr_en, .ext_wr_addr, .ext_wr_data);
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic end_sim;
		if (failures == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic rw(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rr(input logic [2:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		// value launched one edge back still stands before this edge's update
		@(posedge clk);
		chk(reg_rdata, e);
	endtask
	// runs one instruction; raises all flags in cycle at
	task automatic ins(input logic [15:0] op, input logic [7:0] d, input int at);
		{fa, fd, pa, ea, ed, pg, pd, cl, sv, n} = '0;
		@(posedge clk);
		instr_valid <= 1'b1;
		opcode <= op;
		file_rdata <= d;
		@(posedge clk);
		instr_valid <= 1'b0;
		repeat (40) begin
			n++;
			if (n == at) irq_flag <= 4'hf;
			#1;
			if (file_wr_en) {fa, fd} = {8'h00, file_wr_addr, 8'h00, file_wr_data};
			if (prog_active) {pg, pd} = {prog_addr, prog_data};
			if (pm_rd_en) pa = pm_rd_addr;
			if (ext_wr_en) {ea, ed} = {ext_wr_addr, ext_wr_data};
			cl = cl | irq_flag_clr;
			sv = sv | service_req;
			if (done === 1'b1) break;
			@(posedge clk);
		end
	endtask
	initial forever #2 clk = ~clk;
	initial begin
		#5000;
		failures++;
		end_sim;
	end
	initial begin
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		for (int a = 0; a < 8; a++) rr(a[2:0], 8'h00);
		rw(3'h7, 8'hff);
		rr(3'h7, 8'h00);
		rw(3'h0, 8'h34);
		rw(3'h1, 8'h12);
		ins({OP_READ_PREFIX, 2'b01, 8'h50}, 8'h00, 0);
		chk(n, 3);
		chk({fa[7:0], fd[7:0]}, 16'h5000);
		chk(pa, 16'h1234);
		rr(3'h2, 8'hcb);
		rr(3'h0, 8'h35);
		ins({OP_READ_PREFIX, 2'b10, FILE_PROGRAM_COUNTER}, 8'h00, 0);
		chk(n, 4);
		chk({fa[7:0], fd[7:0]}, 16'h0234);
		rr(3'h0, 8'h35);
		irq_flag <= 4'hf;
		irq_enable <= 4'h9;
		ins({OP_WRITE_PREFIX, 2'b01, 8'h20}, 8'h5a, 0);
		chk(n, 2);
		chk(ea, 16'h1235);
		chk(ed, 16'h355a);
		chk({cl, 3'h0, sv}, 16'h0010);
		rr(3'h0, 8'h36);
		for (int k = 0; k < 3; k++) begin
			global_interrupt_disable <= k[0];
			irq_enable <= 4'h1 << k;
			irq_flag <= 4'hf ^ (4'h1 << k);
			rw(3'h0, 8'h10);
			rw(3'h1, 8'h00);
			ins({OP_WRITE_PREFIX, 2'b11, 8'h20}, 8'hc3, 5);
			chk(n, 6);
			chk({cl, 3'h0, sv}, {4'h1 << k, 3'h0, ~k[0]});
			chk(pg, 16'h0010);
			chk(pd, 16'hc35a);
			rr(3'h0, 8'h11);
			rr(3'h3, 8'hc3);
		end
		end_sim;
	end
endmodule
bind ptt_table_xfer ptt_table_xfer_props ptt_table_xfer_props_inst (.clk, .reset_n,
	.instr_valid, .opcode, .busy, .done, .file_wr_en, .pm_rd_en, .ext_wr_en, .prog_active,
	.service_req, .global_interrupt_disable, .irq_flag, .irq_enable, .irq_flag_clr);
`default_nettype wire
